/* common/relay_ctrl_pkg.sv */
// Constants, field layout and state carrier of the relay alarm controller.
// Assumes a 125 MHz APB clock and a measurement front end on that clock.
//
// Behaviour
// - Four channels: enable, setpoints, delays, direction, failsafe each.
// - Relay one is a plain oil-level alarm on its setpoints.
// - Relay two alarms when sensor is out of water, optionally oil alarm.
// - Relay three alarms on lost sensor signal, optionally a level alarm.
// - Relay four: oil alarm, timed pump run, or percent level alarm.
// - A disabled channel never operates and is hidden from the display.
// - Alarm begins at the on-setpoint, in the chosen direction.
// - Alarm ends only when level crosses the separate off-setpoint.
// - Condition must last the on-delay in seconds before relay alarms.
// - Relay stays in alarm for the off-delay after level returns normal.
// - Direction picks alarm above or below; lamps simply follow the alarm.
// - Failsafe coil is energised when normal, off on alarm; else inverse.
// - Pump starts at the pump-on level once its delay has elapsed.
// - Pump stops and run timer clears when level returns to reset level.
// - Pump also stops at run-time expiry, whichever comes first.
// - Level passes a damping filter whose time is set in seconds.

`default_nettype none

package relay_ctrl_pkg;

	localparam int unsigned CLK_NS = 8;
	localparam int unsigned SEC_NS = 1_000_000_000;
	localparam int unsigned TICK_CYCLES = SEC_NS / CLK_NS;
	localparam int unsigned NCH = 4;
	localparam int unsigned LW = 16;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KEY = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_FILT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [3:0] OFS_SETPT_HI = 4'h2;
	localparam logic [3:0] OFS_DLY_HI = 4'h3;
	localparam logic [7:0] OFS_PUMP_LVL = 8'h40;
	localparam logic [7:0] OFS_PUMP_TIME = 8'h44;

	localparam int unsigned CTRL_EN_LSB = 0;
	localparam int unsigned CTRL_DIR_LSB = 4;
	localparam int unsigned CTRL_FS_LSB = 8;
	localparam int unsigned CTRL_AIR_BIT = 12;
	localparam int unsigned CTRL_FLT_BIT = 13;
	localparam int unsigned CTRL_F4_LSB = 14;
	localparam int unsigned CTRL_FILT_LSB = 16;

	localparam logic [31:0] CTRL_RST = 32'h0000_30ff;
	localparam logic [31:0] SETPT_RST = 32'h000f_0014;
	localparam logic [31:0] DLY_RST = 32'h000a_000a;
	localparam logic [31:0] PASSCODE = 32'h0000_07d0;
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_PUMP_BIT = 4;

	typedef enum logic [1:0] {
		F4_OIL = 2'h0,
		F4_PUMP = 2'h1,
		F4_PCT = 2'h2
	} r4_func_t;

	typedef enum logic [3:0] {
		P_IDLE = 4'b0001,
		P_DELAY = 4'b0010,
		P_RUN = 4'b0100,
		P_DONE = 4'b1000
	} pump_st_t;

	typedef struct packed {
		logic [15:0] level;
		logic [15:0] pct;
		logic air;
		logic nosig;
	} meas_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic unlocked;
		logic [3:0][31:0] setpt;
		logic [3:0][31:0] dly;
		logic [31:0] pump_lvl;
		logic [31:0] pump_time;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		logic [3:0] cond;
		logic [3:0] alarm;
		logic [3:0][15:0] cnt;
		pump_st_t pst;
		logic [15:0] pcnt;
		logic [31:0] tick_cnt;
		logic tick;
		logic [15:0] filt;
		logic [15:0] pfilt;
		logic [3:0] coil;
		logic [3:0] show;
		logic [3:0] lamp;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

endpackage : relay_ctrl_pkg

`default_nettype wire

/* rtl/relay_ctrl.sv */
// Relay alarm controller: APB registers, level damping, four relay channels.
// Assumes meas inputs come from logic on pclk and change at any cycle.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module relay_ctrl #(
	parameter int unsigned TICK_LEN = relay_ctrl_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire relay_ctrl_pkg::meas_t meas,
	output logic [3:0] coil,
	output logic [3:0] show,
	output logic [3:0] lamp,
	output logic irq
);

	relay_ctrl_pkg::state_t r, n;

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign coil = r.coil;
	assign show = r.show;
	assign lamp = r.lamp;
	assign irq = r.irq;

	// Damped step of one second toward the target; divisor is the filter time
	function automatic logic [15:0] damp(input logic [15:0] cur,
		input logic [15:0] tgt, input logic [7:0] secs);
		logic signed [17:0] d;
		logic signed [17:0] s;
		d = $signed({2'b00, tgt}) - $signed({2'b00, cur});
		s = d / $signed({10'h000, secs});
		if (s == 18'sd0 && d != 18'sd0)
			s = (d > 18'sd0) ? 18'sd1 : -18'sd1;
		damp = 16'(($signed({2'b00, cur}) + s));
	endfunction : damp

	always_comb begin
		logic acc;
		logic cfg_ok;
		logic [4:0] clr;
		logic [4:0] set;
		logic [3:0] en;
		logic [3:0] dir;
		logic [3:0] fs;
		logic [1:0] f4;
		logic [7:0] fsec;
		logic [15:0] lv;
		logic [15:0] son;
		logic [15:0] soff;
		logic [15:0] dl;
		logic hit_on;
		logic hit_off;
		logic fixed;
		logic pump;
		logic [15:0] pon;
		logic [15:0] prst;
		n = r;
		acc = psel & penable & ~r.pready;
		cfg_ok = r.unlocked;
		clr = 5'h00;
		set = 5'h00;
		en = 4'h0;
		dir = 4'h0;
		fs = 4'h0;
		f4 = 2'h0;
		fsec = 8'h00;
		lv = 16'h0000;
		son = 16'h0000;
		soff = 16'h0000;
		dl = 16'h0000;
		hit_on = 1'b0;
		hit_off = 1'b0;
		fixed = 1'b0;
		pump = 1'b0;
		pon = 16'h0000;
		prst = 16'h0000;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.tick = 1'b0;

		if (r.tick_cnt >= TICK_LEN - 1) begin
			n.tick_cnt = 32'h0000_0000;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = r.tick_cnt + 32'h0000_0001;
		end

		// Register access: one wait state, then pready with data
		if (acc) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (paddr[1:0] != 2'b00) begin
				n.pslverr = 1'b1;
			end else if (pwrite) begin
				if (paddr == relay_ctrl_pkg::OFS_KEY) begin
					n.unlocked = (pwdata == relay_ctrl_pkg::PASSCODE);
				end else if (paddr == relay_ctrl_pkg::OFS_IRQ_STAT) begin
					clr = pwdata[4:0];
				end else if (paddr == relay_ctrl_pkg::OFS_IRQ_MASK) begin
					n.irq_mask = pwdata[4:0];
				end else if (!cfg_ok) begin
					// Locked panel: configuration stays as it was
					n.pslverr = 1'b1;
				end else if (paddr == relay_ctrl_pkg::OFS_CTRL) begin
					n.ctrl = pwdata;
				end else if (paddr[7:4] == relay_ctrl_pkg::OFS_SETPT_HI) begin
					n.setpt[paddr[3:2]] = pwdata;
				end else if (paddr[7:4] == relay_ctrl_pkg::OFS_DLY_HI) begin
					n.dly[paddr[3:2]] = pwdata;
				end else if (paddr == relay_ctrl_pkg::OFS_PUMP_LVL) begin
					n.pump_lvl = pwdata;
				end else if (paddr == relay_ctrl_pkg::OFS_PUMP_TIME) begin
					n.pump_time = pwdata;
				end else begin
					n.pslverr = 1'b1;
				end
			end else begin
				if (paddr == relay_ctrl_pkg::OFS_CTRL) begin
					n.prdata = r.ctrl;
				end else if (paddr == relay_ctrl_pkg::OFS_KEY) begin
					n.prdata = {31'h0000_0000, r.unlocked};
				end else if (paddr == relay_ctrl_pkg::OFS_STAT) begin
					n.prdata = {16'h0000, 4'h0, r.pst, r.coil, r.alarm};
				end else if (paddr == relay_ctrl_pkg::OFS_FILT) begin
					n.prdata = {r.pfilt, r.filt};
				end else if (paddr == relay_ctrl_pkg::OFS_IRQ_STAT) begin
					n.prdata = {27'h000_0000, r.irq_stat};
				end else if (paddr == relay_ctrl_pkg::OFS_IRQ_MASK) begin
					n.prdata = {27'h000_0000, r.irq_mask};
				end else if (paddr[7:4] == relay_ctrl_pkg::OFS_SETPT_HI) begin
					n.prdata = r.setpt[paddr[3:2]];
				end else if (paddr[7:4] == relay_ctrl_pkg::OFS_DLY_HI) begin
					n.prdata = r.dly[paddr[3:2]];
				end else if (paddr == relay_ctrl_pkg::OFS_PUMP_LVL) begin
					n.prdata = r.pump_lvl;
				end else if (paddr == relay_ctrl_pkg::OFS_PUMP_TIME) begin
					n.prdata = r.pump_time;
				end else begin
					n.pslverr = 1'b1;
				end
			end
		end

		en = r.ctrl[relay_ctrl_pkg::CTRL_EN_LSB +: 4];
		dir = r.ctrl[relay_ctrl_pkg::CTRL_DIR_LSB +: 4];
		fs = r.ctrl[relay_ctrl_pkg::CTRL_FS_LSB +: 4];
		f4 = r.ctrl[relay_ctrl_pkg::CTRL_F4_LSB +: 2];
		fsec = r.ctrl[relay_ctrl_pkg::CTRL_FILT_LSB +: 8];
		pump = (f4 == relay_ctrl_pkg::F4_PUMP);

		// Zero seconds means no damping; otherwise one step per second
		if (fsec == 8'h00) begin
			n.filt = meas.level;
			n.pfilt = meas.pct;
		end else if (r.tick) begin
			n.filt = damp(r.filt, meas.level, fsec);
			n.pfilt = damp(r.pfilt, meas.pct, fsec);
		end

		for (int i = 0; i < 4; i++) begin
			lv = (i == 3 && f4 == relay_ctrl_pkg::F4_PCT) ?
				r.pfilt : r.filt;
			son = r.setpt[i][15:0];
			soff = r.setpt[i][31:16];
			// Above: alarm at or over on-point, clear at or under off-point
			hit_on = dir[i] ? (lv >= son) : (lv <= son);
			hit_off = dir[i] ? (lv <= soff) : (lv >= soff);
			fixed = 1'b0;
			if (i == 1 && r.ctrl[relay_ctrl_pkg::CTRL_AIR_BIT]) begin
				fixed = 1'b1;
				n.cond[i] = meas.air;
			end else if (i == 2 && r.ctrl[relay_ctrl_pkg::CTRL_FLT_BIT]) begin
				fixed = 1'b1;
				n.cond[i] = meas.nosig;
			end
			if (!fixed) begin
				if (!r.cond[i] && hit_on)
					n.cond[i] = 1'b1;
				else if (r.cond[i] && hit_off)
					n.cond[i] = 1'b0;
			end
			dl = r.cond[i] ? r.dly[i][15:0] : r.dly[i][31:16];
			if (!en[i]) begin
				n.cond[i] = 1'b0;
				n.alarm[i] = 1'b0;
				n.cnt[i] = 16'h0000;
			end else if (i == 3 && pump) begin
				n.alarm[i] = (r.pst == relay_ctrl_pkg::P_RUN);
				n.cnt[i] = 16'h0000;
			end else if (r.cond[i] == r.alarm[i]) begin
				n.cnt[i] = 16'h0000;
			end else if (r.cnt[i] >= dl) begin
				n.alarm[i] = r.cond[i];
				n.cnt[i] = 16'h0000;
			end else if (r.tick) begin
				n.cnt[i] = r.cnt[i] + 16'h0001;
			end
			if (n.alarm[i] && !r.alarm[i])
				set[i] = 1'b1;
			// Disabled coils stay dead regardless of failsafe
			n.coil[i] = en[i] & (fs[i] ? ~r.alarm[i] : r.alarm[i]);
			n.show[i] = en[i];
			n.lamp[i] = en[i] & r.alarm[i];
		end

		pon = r.pump_lvl[15:0];
		prst = r.pump_lvl[31:16];
		if (!pump || !en[3]) begin
			n.pst = relay_ctrl_pkg::P_IDLE;
			n.pcnt = 16'h0000;
		end else begin
			unique case (r.pst)
				relay_ctrl_pkg::P_IDLE: begin
					n.pcnt = 16'h0000;
					if (r.filt >= pon)
						n.pst = relay_ctrl_pkg::P_DELAY;
				end
				relay_ctrl_pkg::P_DELAY: begin
					if (r.filt < pon) begin
						n.pst = relay_ctrl_pkg::P_IDLE;
						n.pcnt = 16'h0000;
					end else if (r.pcnt >= r.pump_time[15:0]) begin
						n.pst = relay_ctrl_pkg::P_RUN;
						n.pcnt = 16'h0000;
					end else if (r.tick) begin
						n.pcnt = r.pcnt + 16'h0001;
					end
				end
				relay_ctrl_pkg::P_RUN: begin
					if (r.filt <= prst) begin
						n.pst = relay_ctrl_pkg::P_IDLE;
						n.pcnt = 16'h0000;
						set[relay_ctrl_pkg::IRQ_PUMP_BIT] = 1'b1;
					end else if (r.pcnt >= r.pump_time[31:16]) begin
						// Run expired with oil still high: wait for reset level
						n.pst = relay_ctrl_pkg::P_DONE;
						n.pcnt = 16'h0000;
						set[relay_ctrl_pkg::IRQ_PUMP_BIT] = 1'b1;
					end else if (r.tick) begin
						n.pcnt = r.pcnt + 16'h0001;
					end
				end
				relay_ctrl_pkg::P_DONE: begin
					n.pcnt = 16'h0000;
					if (r.filt <= prst)
						n.pst = relay_ctrl_pkg::P_IDLE;
				end
				default: begin
					n.pst = relay_ctrl_pkg::P_IDLE;
					n.pcnt = 16'h0000;
				end
			endcase
		end

		// A new event in the clearing cycle survives the clear
		n.irq_stat = (r.irq_stat & ~clr) | set;
		n.irq = |(n.irq_stat & r.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.ctrl <= relay_ctrl_pkg::CTRL_RST;
			r.setpt <= {4{relay_ctrl_pkg::SETPT_RST}};
			r.dly <= {4{relay_ctrl_pkg::DLY_RST}};
			r.pst <= relay_ctrl_pkg::P_IDLE;
		end else begin
			r <= n;
		end
	end

endmodule : relay_ctrl

`default_nettype wire

/* testbench/relay_ctrl_properties.sv */
// Checker for relay_ctrl: APB timing, lock, display gating and irq.
// Assumes it is bound to relay_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] coil,
	input wire logic [3:0] show,
	input wire logic [3:0] lamp,
	input wire logic irq
);
	logic tk;
	logic unl;
	logic mw;
	assign tk = psel && penable && !pready;
	// Shadow of the key and mask so refusals and irq can be judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl <= 1'b0;
			mw <= 1'b0;
		end else if (tk && pwrite) begin
			if (paddr == 8'h04)
				unl <= (pwdata == 32'h0000_07d0);
			if (paddr == 8'h14 && pwdata[4:0] != 5'h00)
				mw <= 1'b1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_answer;
		tk |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_err;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	property p_lock;
		tk && pwrite && paddr == 8'h00 && !unl |=> pslverr;
	endproperty
	property p_key;
		tk && pwrite && paddr == 8'h04 |=> !pslverr;
	endproperty
	property p_lamp;
		(lamp & ~show) == 4'h0;
	endproperty
	property p_coil;
		(coil & ~show) == 4'h0;
	endproperty
	property p_irq;
		!mw |-> !irq;
	endproperty
	a_answer: assert property (p_answer) else $error("pready late");
	a_pulse: assert property (p_pulse) else $error("pready too long");
	a_err: assert property (p_err) else $error("bad refusal");
	a_lock: assert property (p_lock) else $error("locked write taken");
	a_key: assert property (p_key) else $error("key refused");
	a_lamp: assert property (p_lamp) else $error("hidden lamp");
	a_coil: assert property (p_coil) else $error("disabled coil");
	a_irq: assert property (p_irq) else $error("irq unmasked");
	c_err: cover property (pslverr);
	c_irq: cover property (irq);
	c_pump: cover property ($rose(coil[3]));
endmodule : relay_ctrl_chk
bind relay_ctrl relay_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.coil(coil), .show(show), .lamp(lamp), .irq(irq));
`default_nettype wire

/* testbench/relay_contacts.sv */
// Far side: one normally-open contact per relay coil.
// Assumes coil is 1 when energised.
`timescale 1ns/1ps
`default_nettype none
module relay_contacts (
	input wire logic [3:0] coil,
	output logic [3:0] closed
);
	// No bounce modelled, so timing is judged at the coil itself
	assign closed = coil;
endmodule : relay_contacts
`default_nettype wire

/* testbench/test_level_alarm_relay_control.sv */
// Bench for relay_ctrl: APB master, level stimulus, relay timing checks.
// Assumes TICK_LEN cut to 20 cycles per second.
`timescale 1ns/1ps
`default_nettype none
module test_level_alarm_relay_control;
	localparam int T = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dir;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] coil, show, lamp, closed;
	relay_ctrl_pkg::meas_t meas;
	int n_errors, tests_run, cyc, n, on;
	logic [31:0] rv;
	logic re;
	relay_ctrl #(.TICK_LEN(T)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .meas(meas), .coil(coil), .show(show),
		.lamp(lamp), .irq(irq));
	relay_contacts far_u (.coil(coil), .closed(closed));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// Expected damped value after one filter second: diff/secs, at least 1
	function automatic int step_to(input int c, input int t, input int s);
		int d;
		d = (t - c) / s;
		if (d == 0 && t != c)
			d = (t > c) ? 1 : -1;
		return c + d;
	endfunction : step_to
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("rdata", x, r);
		chk("slverr", 32'(xe), 32'(e));
	endtask : rdc
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk("slverr", 32'(xe), 32'(e));
	endtask : wr
	// Cycles until lamp or contact reaches v must fall in [lo, hi)
	task automatic wt(input logic c, input int ch, input logic v,
		input int lo, input int hi);
		n = 0;
		while ((c ? closed[ch] : lamp[ch]) !== v && n < hi) begin
			@(posedge pclk);
			n++;
		end
		chk("delay", 32'h1, 32'(n >= lo && n < hi));
	endtask : wt
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 10000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		meas = '0;
		presetn = 1'b0;
		{n_errors, tests_run, cyc} = '0;
		on = $urandom(26471);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("show", 32'hf, 32'(show));
		rdc(8'h00, 32'h0000_30ff, 0);
		rdc(8'h20, 32'h000f_0014, 0);
		rdc(8'h3c, 32'h000a_000a, 0);
		rdc(8'hfc, 32'h0, 1);
		wr(8'h00, 32'h0, 1);
		wr(8'h04, 32'h7d0, 0);
		wr(8'h14, 32'h1, 0);
		wr(8'h30, 32'h0002_0002, 0);
		wr(8'h00, 32'h0000_00ff, 0);
		meas.level <= 16'd25;
		repeat (T - 5) @(posedge pclk);
		meas.level <= 16'd10;
		repeat (5) @(posedge pclk);
		meas.level <= 16'd25;
		wt(0, 0, 1, T, 3 * T + 10);
		chk("irq", 32'h1, 32'(irq));
		chk("contact", 32'h1, 32'(closed[0]));
		meas.level <= 16'd17;
		repeat (4 * T) @(posedge pclk);
		chk("held", 32'h1, 32'(lamp[0]));
		wr(8'h10, 32'h1, 0);
		@(posedge pclk);
		chk("irq", 32'h0, 32'(irq));
		wr(8'h00, 32'h0000_01ff, 0);
		repeat (3) @(posedge pclk);
		chk("contact", 32'h0, 32'(closed[0]));
		meas.level <= 16'd10;
		wt(0, 0, 0, T, 3 * T + 10);
		chk("contact", 32'h1, 32'(closed[0]));
		wr(8'h00, 32'h0000_01fe, 0);
		repeat (3) @(posedge pclk);
		chk("show", 32'he, 32'(show));
		chk("contact", 32'h0, 32'(closed[0]));
		wr(8'h30, 32'h0, 0);
		for (int i = 0; i < 4; i++) begin
			dir = i[0];
			on = 20 + $urandom_range(200);
			wr(8'h00, 32'h0000_00ee | 32'(dir) << 4, 0);
			wr(8'h20, {16'(dir ? on - 5 : on + 5), 16'(on)}, 0);
			meas.level <= dir ? 16'd0 : 16'd1000;
			repeat (5) @(posedge pclk);
			wr(8'h00, 32'h0000_00ef | 32'(dir) << 4, 0);
			meas.level <= 16'(on);
			wt(0, 0, 1, 0, 10);
			meas.level <= 16'(dir ? on - 6 : on + 6);
			wt(0, 0, 0, 0, 10);
		end
		meas.level <= 16'd0;
		repeat (12 * T) @(posedge pclk);
		wr(8'h00, 32'h0000_30ff, 0);
		meas.air <= 1'b1;
		wt(0, 1, 1, 9 * T, 12 * T);
		meas.nosig <= 1'b1;
		wt(0, 2, 1, 9 * T, 12 * T);
		wr(8'h40, 32'h000a_001e, 0);
		wr(8'h44, 32'h0002_0001, 0);
		wr(8'h00, 32'h0000_40ff, 0);
		wr(8'h14, 32'h10, 0);
		meas.level <= 16'd40;
		wt(1, 3, 1, 0, 2 * T + 10);
		wt(1, 3, 0, T, 3 * T + 10);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, 32'(irq));
		meas.level <= 16'd5;
		repeat (5) @(posedge pclk);
		meas.level <= 16'd40;
		wt(1, 3, 1, 0, 2 * T + 10);
		meas.level <= 16'd5;
		wt(1, 3, 0, 0, 6);
		// Filter of 4 s: 29 edges hold one or two one-second steps
		wr(8'h00, 32'h0004_00ff, 0);
		meas.level <= 16'd105;
		repeat (28) @(posedge pclk);
		apb(1'b0, 8'h0c, 32'h0, rv, re);
		on = step_to(5, 105, 4);
		n = step_to(on, 105, 4);
		chk("filter", 32'h1, 32'(rv == 32'(on) || rv == 32'(n)));
		repeat (500) @(posedge pclk);
		rdc(8'h0c, 32'h0000_0069, 0);
		wr(8'h3c, 32'h0, 0);
		wr(8'h00, 32'h0000_80ff, 0);
		repeat (3) @(posedge pclk);
		chk("lamp", 32'h0, 32'(lamp[3]));
		meas.pct <= 16'd50;
		wt(0, 3, 1, 0, 10);
		meas.pct <= 16'd0;
		wt(0, 3, 0, 0, 10);
		// Second reset in mid-run: outputs drop, panel locks again
		presetn <= 1'b0;
		@(posedge pclk);
		chk("show", 32'h0, 32'(show));
		chk("contact", 32'h0, 32'(closed));
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("show", 32'hf, 32'(show));
		wr(8'h00, 32'h0, 1);
		end_sim();
	end
endmodule : test_level_alarm_relay_control
`default_nettype wire
